// [gpio_trigger_filter_config.sv]
// second pin, pin trigger and filter configuration register bank
`timescale 1ns/1ps
// Operation
// - reserved direction or input codes drop the write
// - direction: input, open-drain or push-pull
// - input select: off, conversion or sequence start
// - input or output function follows direction
// - trigger wakes from power down, then starts
// - output codes: high z, interrupts, fixed levels
// - code 101 low-side switch overrides push-pull
// - codes 110 modulator active, 111 system clock
// - setup write stores only, starts nothing
// - destination field picks result register zero-seven
// - kind: single, continuous or duty-cycled
// - start address write stores only
// - only addresses 0x3A to 0x6F accepted
// - sequence starts at stored pointer, reset 0x3A
// - filter type: 50/60, 50, 60, sinc4
// - rate field meaning depends on filter type
module gpio_trigger_filter_config (
  // clock and reset
  input wire logic clk_in,
  input wire logic reset_n_in,
  // register port
  input wire logic reg_write_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  output logic [7:0] reg_rdata_out,
  // system status
  input wire logic deep_power_down_in,
  input wire logic light_power_down_in,
  input wire logic interrupt_pending_in,
  input wire logic modulator_active_in,
  input wire logic low_side_switch_in,
  input wire logic sys_clock_level_in,
  // second pin
  input wire logic pin_in,
  output logic pin_out,
  output logic pin_oe_out,
  // triggers to the conversion engine and sequencer
  output logic wake_request_out,
  output logic conversion_start_out,
  output logic [2:0] triggered_result_destination_out,
  output logic [1:0] triggered_conversion_kind_out,
  output logic sequence_start_out,
  output logic [6:0] sequence_start_pointer_out,
  // filter selection
  output logic [1:0] filter_type_select_out,
  output logic [3:0] rate_select_out
);

  // ==========================================================================
  // state
  typedef struct packed {
    logic [1:0] pin_direction_select;
    logic [1:0] pin_input_function;
    logic [2:0] pin_output_function;
    logic [2:0] triggered_result_destination;
    logic [1:0] triggered_conversion_kind;
    logic [6:0] sequence_start_pointer;
    logic reserved_filter_bit;
    logic [1:0] filter_type_select;
    logic [3:0] rate_select;
    logic sync_first;
    logic sync_second;
    logic sync_prev;
    logic pending_conv;
    logic pending_seq;
    logic wake_request;
    logic conversion_start;
    logic sequence_start;
    logic pin_level;
    logic pin_oe;
    logic [7:0] rdata;
  } state_type;

  state_type state;
  state_type next_state;

  function automatic logic [7:0] read_mux(input state_type s, input logic [7:0] addr);
    logic [7:0] value;
    value = 8'h00;
    unique case (addr)
      gpio_trigger_filter_pkg::SECOND_PIN_CONTROL_ADDR:
        value = {s.pin_direction_select, s.pin_input_function, 1'b0, s.pin_output_function};
      gpio_trigger_filter_pkg::PIN_CONVERSION_SETUP_ADDR:
        value = {1'b0, s.triggered_result_destination, 2'b00, s.triggered_conversion_kind};
      gpio_trigger_filter_pkg::PIN_SEQUENCE_START_ADDRESS_ADDR:
        value = {1'b0, s.sequence_start_pointer};
      gpio_trigger_filter_pkg::FILTER_AND_RATE_SELECT_ADDR:
        value = {1'b0, s.reserved_filter_bit, s.filter_type_select, s.rate_select};
      default:
        value = 8'h00;
    endcase
    return value;
  endfunction

  logic is_input;
  logic is_output;
  logic rising;
  logic powered_down;

  always_comb begin
    next_state = state;
    is_input = (state.pin_direction_select == gpio_trigger_filter_pkg::DIR_INPUT);
    is_output = state.pin_direction_select[1];
    powered_down = deep_power_down_in | light_power_down_in;
    // ==========================================================================
    // pin synchroniser and edge detect
    next_state.sync_first = pin_in;
    next_state.sync_second = state.sync_first;
    next_state.sync_prev = state.sync_second;
    rising = state.sync_second & ~state.sync_prev;
    // ==========================================================================
    // register writes; writes never trigger anything themselves
    if (reg_write_in) begin
      unique case (reg_addr_in)
        gpio_trigger_filter_pkg::SECOND_PIN_CONTROL_ADDR: begin
          // reserved codes leave every field untouched
          if (reg_wdata_in[gpio_trigger_filter_pkg::DIR_HI:gpio_trigger_filter_pkg::DIR_LO]
              != gpio_trigger_filter_pkg::DIR_RESERVED &&
              reg_wdata_in[gpio_trigger_filter_pkg::ISEL_HI:gpio_trigger_filter_pkg::ISEL_LO]
              != gpio_trigger_filter_pkg::ISEL_RESERVED) begin
            next_state.pin_direction_select =
              reg_wdata_in[gpio_trigger_filter_pkg::DIR_HI:gpio_trigger_filter_pkg::DIR_LO];
            next_state.pin_input_function =
              reg_wdata_in[gpio_trigger_filter_pkg::ISEL_HI:gpio_trigger_filter_pkg::ISEL_LO];
            next_state.pin_output_function =
              reg_wdata_in[gpio_trigger_filter_pkg::OSEL_HI:gpio_trigger_filter_pkg::OSEL_LO];
          end
        end
        gpio_trigger_filter_pkg::PIN_CONVERSION_SETUP_ADDR: begin
          next_state.triggered_result_destination =
            reg_wdata_in[gpio_trigger_filter_pkg::DEST_HI:gpio_trigger_filter_pkg::DEST_LO];
          next_state.triggered_conversion_kind =
            reg_wdata_in[gpio_trigger_filter_pkg::KIND_HI:gpio_trigger_filter_pkg::KIND_LO];
        end
        gpio_trigger_filter_pkg::PIN_SEQUENCE_START_ADDRESS_ADDR: begin
          if (reg_wdata_in[7] == 1'b0 &&
              reg_wdata_in[6:0] >= gpio_trigger_filter_pkg::SEQ_ADDR_MIN &&
              reg_wdata_in[6:0] <= gpio_trigger_filter_pkg::SEQ_ADDR_MAX) begin
            next_state.sequence_start_pointer = reg_wdata_in[6:0];
          end
        end
        gpio_trigger_filter_pkg::FILTER_AND_RATE_SELECT_ADDR: begin
          // bit six kept as written so a careless host can see it
          next_state.reserved_filter_bit = reg_wdata_in[6];
          next_state.filter_type_select =
            reg_wdata_in[gpio_trigger_filter_pkg::FTYPE_HI:gpio_trigger_filter_pkg::FTYPE_LO];
          next_state.rate_select =
            reg_wdata_in[gpio_trigger_filter_pkg::RATE_HI:gpio_trigger_filter_pkg::RATE_LO];
        end
        default: begin
        end
      endcase
    end
    // ==========================================================================
    // pin triggers, with wake before start when powered down
    next_state.wake_request = 1'b0;
    next_state.conversion_start = 1'b0;
    next_state.sequence_start = 1'b0;
    if (state.pending_conv | state.pending_seq) begin
      if (!powered_down) begin
        next_state.conversion_start = state.pending_conv;
        next_state.sequence_start = state.pending_seq;
        next_state.pending_conv = 1'b0;
        next_state.pending_seq = 1'b0;
      end else begin
        next_state.wake_request = 1'b1;
      end
    end else if (rising && is_input) begin
      // a pulse shorter than one clock may be missed by the sampler
      if (state.pin_input_function == gpio_trigger_filter_pkg::ISEL_CONV) begin
        next_state.pending_conv = 1'b1;
        next_state.wake_request = powered_down;
      end else if (state.pin_input_function == gpio_trigger_filter_pkg::ISEL_SEQ) begin
        next_state.pending_seq = 1'b1;
        next_state.wake_request = powered_down;
      end
    end
    // ==========================================================================
    // output function
    next_state.pin_level = 1'b0;
    next_state.pin_oe = 1'b0;
    if (is_output) begin
      unique case (state.pin_output_function)
        gpio_trigger_filter_pkg::OSEL_HIGH_Z: begin
          next_state.pin_level = 1'b0;
        end
        gpio_trigger_filter_pkg::OSEL_INT_LOW: begin
          next_state.pin_level = ~interrupt_pending_in;
          next_state.pin_oe = 1'b1;
        end
        gpio_trigger_filter_pkg::OSEL_INT_HIGH: begin
          next_state.pin_level = interrupt_pending_in;
          next_state.pin_oe = 1'b1;
        end
        gpio_trigger_filter_pkg::OSEL_LOGIC0: begin
          next_state.pin_level = 1'b0;
          next_state.pin_oe = 1'b1;
        end
        gpio_trigger_filter_pkg::OSEL_LOGIC1: begin
          next_state.pin_level = 1'b1;
          next_state.pin_oe = 1'b1;
        end
        gpio_trigger_filter_pkg::OSEL_LOW_SWITCH: begin
          // switch only sinks, so it stays open drain even in push-pull
          next_state.pin_level = 1'b0;
          next_state.pin_oe = low_side_switch_in;
        end
        gpio_trigger_filter_pkg::OSEL_MOD_ACTIVE: begin
          next_state.pin_level = modulator_active_in;
          next_state.pin_oe = 1'b1;
        end
        gpio_trigger_filter_pkg::OSEL_SYS_CLOCK: begin
          // registered copy: lags a cycle, fine for a divided clock level
          next_state.pin_level = sys_clock_level_in;
          next_state.pin_oe = 1'b1;
        end
      endcase
      // open drain drives only the low level
      if (state.pin_direction_select == gpio_trigger_filter_pkg::DIR_OPEN_DRAIN &&
          state.pin_output_function != gpio_trigger_filter_pkg::OSEL_LOW_SWITCH) begin
        next_state.pin_oe = next_state.pin_oe & ~next_state.pin_level;
        next_state.pin_level = 1'b0;
      end
    end
    next_state.rdata = read_mux(state, reg_addr_in);
  end

  // ==========================================================================
  // registers
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      state <= '0;
      state.sequence_start_pointer <= gpio_trigger_filter_pkg::SEQUENCE_START_POINTER_RESET;
    end else begin
      state <= next_state;
    end
  end

  assign reg_rdata_out = state.rdata;
  assign pin_out = state.pin_level;
  assign pin_oe_out = state.pin_oe;
  assign wake_request_out = state.wake_request;
  assign conversion_start_out = state.conversion_start;
  assign triggered_result_destination_out = state.triggered_result_destination;
  assign triggered_conversion_kind_out = state.triggered_conversion_kind;
  assign sequence_start_out = state.sequence_start;
  assign sequence_start_pointer_out = state.sequence_start_pointer;
  assign filter_type_select_out = state.filter_type_select;
  assign rate_select_out = state.rate_select;

endmodule

// [gpio_trigger_filter_pkg.sv]
// constants for the second pin, trigger and filter configuration block
package gpio_trigger_filter_pkg;
  // ==========================================================================
  // register offsets
  localparam logic [7:0] SECOND_PIN_CONTROL_ADDR = 8'h05;
  localparam logic [7:0] PIN_CONVERSION_SETUP_ADDR = 8'h06;
  localparam logic [7:0] PIN_SEQUENCE_START_ADDRESS_ADDR = 8'h07;
  localparam logic [7:0] FILTER_AND_RATE_SELECT_ADDR = 8'h08;
  // ==========================================================================
  // field positions
  localparam int DIR_HI = 7;
  localparam int DIR_LO = 6;
  localparam int ISEL_HI = 5;
  localparam int ISEL_LO = 4;
  localparam int OSEL_HI = 2;
  localparam int OSEL_LO = 0;
  localparam int DEST_HI = 6;
  localparam int DEST_LO = 4;
  localparam int KIND_HI = 1;
  localparam int KIND_LO = 0;
  localparam int FTYPE_HI = 5;
  localparam int FTYPE_LO = 4;
  localparam int RATE_HI = 3;
  localparam int RATE_LO = 0;
  // ==========================================================================
  // codes
  localparam logic [1:0] DIR_INPUT = 2'h0;
  localparam logic [1:0] DIR_RESERVED = 2'h1;
  localparam logic [1:0] DIR_OPEN_DRAIN = 2'h2;
  localparam logic [1:0] DIR_PUSH_PULL = 2'h3;
  localparam logic [1:0] ISEL_OFF = 2'h0;
  localparam logic [1:0] ISEL_CONV = 2'h1;
  localparam logic [1:0] ISEL_SEQ = 2'h2;
  localparam logic [1:0] ISEL_RESERVED = 2'h3;
  localparam logic [2:0] OSEL_HIGH_Z = 3'h0;
  localparam logic [2:0] OSEL_INT_LOW = 3'h1;
  localparam logic [2:0] OSEL_INT_HIGH = 3'h2;
  localparam logic [2:0] OSEL_LOGIC0 = 3'h3;
  localparam logic [2:0] OSEL_LOGIC1 = 3'h4;
  localparam logic [2:0] OSEL_LOW_SWITCH = 3'h5;
  localparam logic [2:0] OSEL_MOD_ACTIVE = 3'h6;
  localparam logic [2:0] OSEL_SYS_CLOCK = 3'h7;
  localparam logic [1:0] KIND_SINGLE = 2'h0;
  localparam logic [1:0] KIND_CONTINUOUS = 2'h1;
  localparam logic [6:0] SEQ_ADDR_MIN = 7'h3A;
  localparam logic [6:0] SEQ_ADDR_MAX = 7'h6F;
  // ==========================================================================
  // reset values and read masks
  localparam logic [7:0] SECOND_PIN_CONTROL_RESET = 8'h00;
  localparam logic [7:0] PIN_CONVERSION_SETUP_RESET = 8'h00;
  localparam logic [6:0] SEQUENCE_START_POINTER_RESET = 7'h3A;
  localparam logic [7:0] FILTER_AND_RATE_SELECT_RESET = 8'h00;
  localparam logic [7:0] SECOND_PIN_CONTROL_MASK = 8'hF7;
  localparam logic [7:0] PIN_CONVERSION_SETUP_MASK = 8'h73;
  localparam logic [7:0] FILTER_AND_RATE_SELECT_MASK = 8'h7F;
endpackage

// [gpio_trigger_filter_config_chk.sv]
// assertion checker for the pin, trigger and filter register bank
`timescale 1ns/1ps
module gpio_trigger_filter_config_chk (
  // clock and reset
  input wire logic clk_in,
  input wire logic reset_n_in,
  // register port
  input wire logic reg_write_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  // status and pin
  input wire logic deep_power_down_in,
  input wire logic light_power_down_in,
  input wire logic pin_in,
  // outputs
  input wire logic wake_request_out,
  input wire logic conversion_start_out,
  input wire logic sequence_start_out,
  input wire logic [2:0] triggered_result_destination_out,
  input wire logic [1:0] triggered_conversion_kind_out,
  input wire logic [6:0] sequence_start_pointer_out,
  input wire logic [1:0] filter_type_select_out,
  input wire logic [3:0] rate_select_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!reset_n_in);
  // ==========================================================================
  // properties
  reset_value_a: assert property (disable iff (1'b0) !reset_n_in |=>
    sequence_start_pointer_out == 7'h3A && !conversion_start_out) else $error("bad reset");
  start_cause_a: assert property ((conversion_start_out || sequence_start_out) &&
    !$past(wake_request_out) && !$past(wake_request_out, 2) |->
    $past(pin_in, 3) && $past(pin_in, 4) && !$past(pin_in, 5)) else $error("start no edge");
  ptr_hold_a: assert property (!(reg_write_in && reg_addr_in == 8'h07) |=>
    $stable(sequence_start_pointer_out)) else $error("pointer moved");
  ptr_write_a: assert property (reg_write_in && reg_addr_in == 8'h07 &&
    reg_wdata_in >= 8'h3A && reg_wdata_in <= 8'h6F |=>
    sequence_start_pointer_out == $past(reg_wdata_in[6:0])) else $error("pointer lost");
  setup_write_a: assert property (reg_write_in && reg_addr_in == 8'h06 |=>
    triggered_result_destination_out == $past(reg_wdata_in[6:4]) &&
    triggered_conversion_kind_out == $past(reg_wdata_in[1:0])) else $error("setup lost");
  filter_write_a: assert property (reg_write_in && reg_addr_in == 8'h08 |=>
    filter_type_select_out == $past(reg_wdata_in[5:4]) &&
    rate_select_out == $past(reg_wdata_in[3:0])) else $error("filter lost");
  wake_cause_a: assert property ($rose(wake_request_out) |->
    $past(deep_power_down_in) || $past(light_power_down_in)) else $error("wake awake");
  wake_hold_a: assert property (wake_request_out && (deep_power_down_in ||
    light_power_down_in) |=> wake_request_out && !conversion_start_out && !sequence_start_out)
    else $error("start asleep");
  pulse_one_a: assert property (conversion_start_out |=>
    !conversion_start_out) else $error("long start");
endmodule
bind gpio_trigger_filter_config gpio_trigger_filter_config_chk chk (.*);

// [gpio_host_model.sv]
// host model: register writes, reads and pin pulses
`timescale 1ns/1ps
module gpio_host_model (
  // clock
  input wire logic clk_in,
  // register port
  output logic reg_write_out,
  output logic [7:0] reg_addr_out,
  output logic [7:0] reg_wdata_out,
  input wire logic [7:0] reg_rdata_in,
  // pin
  output logic pin_drive_out
);
  initial begin
    reg_write_out = 1'b0;
    reg_addr_out = 8'h00;
    reg_wdata_out = 8'h00;
    pin_drive_out = 1'b0;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_in);
    reg_write_out = 1'b1;
    reg_addr_out = a;
    reg_wdata_out = (a == 8'h08) ? (d & 8'hBF) : d;
    @(negedge clk_in);
    reg_write_out = 1'b0;
    reg_wdata_out = ~reg_wdata_out;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk_in);
    reg_addr_out = a;
    @(negedge clk_in);
    d = reg_rdata_in;
  endtask
  // shortest legal pulse and gap, the hardest case
  task automatic pulse();
    @(negedge clk_in);
    pin_drive_out = 1'b1;
    repeat (2) @(negedge clk_in);
    pin_drive_out = 1'b0;
    repeat (2) @(negedge clk_in);
  endtask
endmodule

// [tb_gpio_trigger_filter_config.sv]
// self-checking bench for the pin, trigger and filter register bank
`timescale 1ns/1ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin mismatches++; \
  $display("[ERR] t=%0t got=%h exp=%h", $time, g, e); end end
module tb_gpio_trigger_filter_config;
  logic clk_in, reset_n_in, deep, light, irq, mod_act, lsw, sclk;
  logic we, host_pin, pin_out, pin_oe, wake, conv, seq, c, s;
  logic [7:0] addr, wdata, rdata, f;
  logic [2:0] dest;
  logic [1:0] kind, ftype;
  logic [6:0] ptr;
  logic [3:0] rate;
  int mismatches = 0;
  int n_compared = 0;
  logic [7:0] sw [6] = '{8'h39, 8'h6F, 8'h70, 8'hBA, 8'h3A, 8'h45};
  logic [7:0] se [6] = '{8'h3A, 8'h6F, 8'h6F, 8'h6F, 8'h3A, 8'h45};
  // the pin wire: device wins while it drives
  wire pin_level = pin_oe ? pin_out : host_pin;
  gpio_host_model host (.clk_in(clk_in), .reg_write_out(we), .reg_addr_out(addr),
    .reg_wdata_out(wdata), .reg_rdata_in(rdata), .pin_drive_out(host_pin));
  gpio_trigger_filter_config dut (.clk_in(clk_in), .reset_n_in(reset_n_in),
    .reg_write_in(we), .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_rdata_out(rdata),
    .deep_power_down_in(deep), .light_power_down_in(light), .interrupt_pending_in(irq),
    .modulator_active_in(mod_act), .low_side_switch_in(lsw), .sys_clock_level_in(sclk),
    .pin_in(pin_level), .pin_out(pin_out), .pin_oe_out(pin_oe), .wake_request_out(wake),
    .conversion_start_out(conv), .triggered_result_destination_out(dest),
    .triggered_conversion_kind_out(kind), .sequence_start_out(seq),
    .sequence_start_pointer_out(ptr), .filter_type_select_out(ftype), .rate_select_out(rate));
  initial begin
    clk_in = 1'b0;
    forever #20 clk_in = ~clk_in;
  end
  task automatic end_sim();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    host.rd(a, d);
    `CHK(d, e)
  endtask
  task automatic watch();
    c = 1'b0;
    s = 1'b0;
    // sample first: a start pulse may already stand when the pulse task returns
    repeat (10) begin
      c = c | conv;
      s = s | seq;
      @(negedge clk_in);
    end
  endtask
  initial begin
    {reset_n_in, deep, light} = 3'b000;
    {irq, mod_act, lsw, sclk} = 4'hF;
    repeat (5) @(negedge clk_in);
    reset_n_in = 1'b1;
    rchk(8'h05, 8'h00);
    rchk(8'h06, 8'h00);
    rchk(8'h08, 8'h00);
    host.wr(8'h09, 8'hFF);
    rchk(8'h09, 8'h00);
    host.wr(8'h05, 8'h40);
    host.wr(8'h05, 8'h30);
    rchk(8'h05, 8'h00);
    for (int i = 0; i < 6; i++) begin
      host.wr(8'h07, sw[i]);
      rchk(8'h07, se[i]);
    end
    for (int i = 0; i < 4; i++) begin
      f = {2'b00, i[1:0], 4'hC - 4'(i)};
      host.wr(8'h08, f);
      rchk(8'h08, f);
      `CHK({ftype, rate}, f[5:0])
    end
    host.wr(8'h05, 8'h10);
    host.wr(8'h06, 8'h51);
    watch();
    `CHK({c, s, dest, kind}, 7'h15)
    host.pulse();
    watch();
    `CHK({c, s}, 2'b10)
    host.wr(8'h05, 8'h20);
    host.pulse();
    watch();
    `CHK({c, s, ptr}, 9'h0C5)
    host.wr(8'h05, 8'hD0);
    host.pulse();
    watch();
    `CHK({c, s}, 2'b00)
    host.wr(8'h05, 8'h10);
    for (int i = 0; i < 2; i++) begin
      deep = (i == 0);
      light = (i == 1);
      host.pulse();
      watch();
      `CHK({c, s, wake}, 3'b001)
      {deep, light} = 2'b00;
      watch();
      `CHK({c, s, wake}, 3'b100)
    end
    for (int i = 0; i < 8; i++) begin
      host.wr(8'h05, {5'b11000, i[2:0]});
      repeat (3) @(negedge clk_in);
      `CHK({pin_oe, pin_out & (i != 0)}, {i != 0, 1'(8'hD4 >> i)})
    end
    host.wr(8'h05, 8'h84);
    repeat (3) @(negedge clk_in);
    `CHK(pin_oe, 1'b0)
    host.wr(8'h05, 8'h83);
    repeat (3) @(negedge clk_in);
    `CHK({pin_oe, pin_out}, 2'b10)
    lsw = 1'b0;
    host.wr(8'h05, 8'hC5);
    repeat (3) @(negedge clk_in);
    `CHK(pin_oe, 1'b0)
    end_sim();
  end
  initial begin
    repeat (5000) @(posedge clk_in);
    mismatches++;
    end_sim();
  end
endmodule
